// *** rtl/mft_defs.vh ***
// register map, field positions, reset values and timing for the timer control
`ifndef MFT_DEFS_VH
`define MFT_DEFS_VH

// byte offsets of the words on the register bus
`define MFT_OFS_T1_CTRL 8'h00
`define MFT_OFS_T2_FLAGS 8'h04
`define MFT_OFS_IRQ_STAT 8'h08
`define MFT_OFS_IRQ_MASK 8'h0c
`define MFT_OFS_T1_COUNT 8'h10

// timer 1 edge, prescale and mode control
`define MFT_T1_RTOVF 7
`define MFT_T1_CAPEDGE 6
`define MFT_T1_EVTEDGE 5
`define MFT_T1_PS_HI 4
`define MFT_T1_PS_LO 2
`define MFT_T1_MODE_HI 1
`define MFT_T1_MODE_LO 0

// timer 2 flags and enables
`define MFT_T2_CAP2F 7
`define MFT_T2_CAP1F 6
`define MFT_T2_CAPIE 5
`define MFT_T2_MAT2F 4
`define MFT_T2_MAT1F 3
`define MFT_T2_MATIE 2
`define MFT_T2_OVF 1
`define MFT_T2_OVIE 0

// sticky interrupt status bits
`define MFT_IRQ_RTOVF 0
`define MFT_IRQ_CAP 1
`define MFT_IRQ_MAT 2
`define MFT_IRQ_OVF 3

// write-one-to-clear masks of the two control words
`define MFT_T1_W1C 8'h80
`define MFT_T2_W1C 8'hda

// reset values
`define MFT_T1_RST 8'h00
`define MFT_T2_RST 8'h00
`define MFT_MASK_RST 4'h0

// operating modes
`define MFT_MODE_SOFT 2'h0
`define MFT_MODE_PWM 2'h1
`define MFT_MODE_CAPCMP 2'h2
`define MFT_MODE_EVENT 2'h3

// prescaler width, largest divide is 2**7
`define MFT_PS_W 7

`endif

// *** rtl/mft_timer_ctrl.v ***
// timer 1 edge, prescale and mode control with timer 2 flags, over apb
`timescale 1ns/10ps
`default_nettype none
`include "mft_defs.vh"

// Function
// R1: timer 1 control bit 7 sets on real-time counter overflow, held until cleared.
// R2: bit 6 picks capture edge for both timer 1 capture pins, 1 rising.
// R3: bit 5 picks counted edge of timer 1 event pin, 1 rising.
// R4: 3-bit prescale divides clock by two to the field; counter advances per period.
// R5: bits 1..0 select mode: soft timer, pwm, capture/compare, event count.
// R6: in capture/compare mode timer 2 capture flags 2 and 1 set, held.
// R7: capture interrupt enable bit 5 lets capture edges raise interrupts.
// R8: timer 2 match flags bits 4 and 3 set on active compare match, held.
// R9: match interrupt enable bit 2 lets compare matches raise interrupts.
// R10: timer 2 overflow flag bit 1 sets on counter wrap, held until cleared.
// R11: overflow interrupt enable bit 0 lets overflow raise an interrupt.
module mft_timer_ctrl (
  // clock and reset
  input wire i_clk,
  input wire i_rst_b,
  // apb slave
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [7:0] i_paddr,
  input wire [31:0] i_pwdata,
  output reg [31:0] o_prdata,
  output reg o_pready,
  output reg o_pslverr,
  // pins of timer 1
  input wire i_tmr1_capture1_pin,
  input wire i_tmr1_capture2_pin,
  input wire i_tmr1_event_pin,
  // events from neighbouring logic
  input wire i_rt_counter_overflow,
  input wire [1:0] i_tmr2_mode,
  input wire i_tmr2_capture1_evt,
  input wire i_tmr2_capture2_evt,
  input wire i_tmr2_match1_evt,
  input wire i_tmr2_match2_evt,
  input wire i_tmr2_overflow_evt,
  // timer 1 outputs
  output reg [1:0] o_tmr1_mode_field,
  output reg o_tmr1_tick,
  output reg o_tmr1_capture1_evt,
  output reg o_tmr1_capture2_evt,
  output reg [15:0] o_tmr1_count,
  // interrupt
  output reg o_irq
);

  reg [7:0] t1_ctrl;
  reg [7:0] t2_flags;
  reg [3:0] irq_stat;
  reg [3:0] irq_mask;
  reg [6:0] ps_cnt;
  reg [2:0] sync_a;
  reg [2:0] sync_b;
  reg [2:0] prev;
  reg [7:0] next_t1_ctrl;
  reg [7:0] next_t2_flags;
  reg [3:0] next_irq_stat;
  reg [31:0] rd_word;
  reg rd_hit;
  wire wr_en;
  wire acc_en;
  wire ps_hit;
  wire cap_mode;
  wire ev_mode;
  wire t1_cap1;
  wire t1_cap2;
  wire t1_evt;
  wire t2_cap;
  wire t2_mat;
  wire [3:0] irq_evt;

  // mask of prescale bits that must all be one for a tick
  function [6:0] div_mask;
    input [2:0] ps;
    begin
      div_mask = (7'h01 << ps) - 7'h01;
    end
  endfunction

  // true on the selected edge, rising when sel is one
  function edge_hit;
    input cur;
    input old;
    input sel;
    begin
      edge_hit = sel ? (cur & ~old) : (~cur & old);
    end
  endfunction

  assign acc_en = i_psel & i_penable & o_pready;
  assign wr_en = acc_en & i_pwrite;

  // pin synchroniser, first stage
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sync_a <= 3'h0;
    end else begin
      sync_a <= {i_tmr1_event_pin, i_tmr1_capture2_pin, i_tmr1_capture1_pin};
    end
  end

  // pin synchroniser, second stage
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sync_b <= 3'h0;
    end else begin
      sync_b <= sync_a;
    end
  end

  // delayed copy for edge detection, idle low
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      prev <= 3'h0;
    end else begin
      prev <= sync_b;
    end
  end

  // mode decode
  assign cap_mode = t1_ctrl[`MFT_T1_MODE_HI:`MFT_T1_MODE_LO] ==
    `MFT_MODE_CAPCMP;
  assign ev_mode = t1_ctrl[`MFT_T1_MODE_HI:`MFT_T1_MODE_LO] ==
    `MFT_MODE_EVENT;

  // R2: capture edge select
  assign t1_cap1 = cap_mode &
    edge_hit(sync_b[0], prev[0], t1_ctrl[`MFT_T1_CAPEDGE]);
  assign t1_cap2 = cap_mode &
    edge_hit(sync_b[1], prev[1], t1_ctrl[`MFT_T1_CAPEDGE]);

  // R3: event edge select
  assign t1_evt = edge_hit(sync_b[2], prev[2], t1_ctrl[`MFT_T1_EVTEDGE]);

  // R4: prescale divide
  assign ps_hit = (ps_cnt & div_mask(t1_ctrl[`MFT_T1_PS_HI:`MFT_T1_PS_LO]))
    == div_mask(t1_ctrl[`MFT_T1_PS_HI:`MFT_T1_PS_LO]);

  // R4: free prescale counter
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ps_cnt <= 7'h00;
    end else begin
      ps_cnt <= ps_cnt + 7'h01;
    end
  end

  // R5: event mode counts pin edges, others the prescaled clock
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_tmr1_tick <= 1'b0;
    end else begin
      o_tmr1_tick <= ev_mode ? t1_evt : ps_hit;
    end
  end

  // R4: counter advances once per tick
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_tmr1_count <= 16'h0000;
    end else begin
      if (ev_mode ? t1_evt : ps_hit) begin
        o_tmr1_count <= o_tmr1_count + 16'h0001;
      end
    end
  end

  // capture one strobe toward the capture datapath
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_tmr1_capture1_evt <= 1'b0;
    end else begin
      o_tmr1_capture1_evt <= t1_cap1;
    end
  end

  // capture two strobe toward the capture datapath
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_tmr1_capture2_evt <= 1'b0;
    end else begin
      o_tmr1_capture2_evt <= t1_cap2;
    end
  end

  // mode field copy for the timer datapath
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_tmr1_mode_field <= `MFT_MODE_SOFT;
    end else begin
      o_tmr1_mode_field <= t1_ctrl[`MFT_T1_MODE_HI:`MFT_T1_MODE_LO];
    end
  end

  // timer 2 event qualification
  assign t2_cap = (i_tmr2_mode == `MFT_MODE_CAPCMP) &
    (i_tmr2_capture1_evt | i_tmr2_capture2_evt);
  assign t2_mat = i_tmr2_match1_evt | i_tmr2_match2_evt;

  // R7: capture interrupt gate
  // R9: match interrupt gate
  // R11: overflow interrupt gate
  assign irq_evt = {
    i_tmr2_overflow_evt & t2_flags[`MFT_T2_OVIE],
    t2_mat & t2_flags[`MFT_T2_MATIE],
    t2_cap & t2_flags[`MFT_T2_CAPIE],
    i_rt_counter_overflow
  };

  // next value of control words, set beats clear
  always @* begin
    next_t1_ctrl = t1_ctrl;
    next_t2_flags = t2_flags;
    next_irq_stat = irq_stat;
    if (wr_en && i_paddr == `MFT_OFS_T1_CTRL) begin
      next_t1_ctrl = (i_pwdata[7:0] & ~`MFT_T1_W1C) |
        (t1_ctrl & `MFT_T1_W1C & ~i_pwdata[7:0]);
    end else if (wr_en && i_paddr == `MFT_OFS_T2_FLAGS) begin
      next_t2_flags = (i_pwdata[7:0] & ~`MFT_T2_W1C) |
        (t2_flags & `MFT_T2_W1C & ~i_pwdata[7:0]);
    end else if (wr_en && i_paddr == `MFT_OFS_IRQ_STAT) begin
      next_irq_stat = irq_stat & ~i_pwdata[3:0];
    end
    // R1: real-time overflow flag
    if (i_rt_counter_overflow) begin
      next_t1_ctrl[`MFT_T1_RTOVF] = 1'b1;
    end
    // R6: capture flags in capture/compare mode
    if (i_tmr2_mode == `MFT_MODE_CAPCMP && i_tmr2_capture2_evt) begin
      next_t2_flags[`MFT_T2_CAP2F] = 1'b1;
    end
    if (i_tmr2_mode == `MFT_MODE_CAPCMP && i_tmr2_capture1_evt) begin
      next_t2_flags[`MFT_T2_CAP1F] = 1'b1;
    end
    // R8: compare match flags
    if (i_tmr2_match2_evt) begin
      next_t2_flags[`MFT_T2_MAT2F] = 1'b1;
    end
    if (i_tmr2_match1_evt) begin
      next_t2_flags[`MFT_T2_MAT1F] = 1'b1;
    end
    // R10: overflow flag
    if (i_tmr2_overflow_evt) begin
      next_t2_flags[`MFT_T2_OVF] = 1'b1;
    end
    next_irq_stat = next_irq_stat | irq_evt;
  end

  // timer 1 control word
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      t1_ctrl <= `MFT_T1_RST;
    end else begin
      t1_ctrl <= next_t1_ctrl;
    end
  end

  // timer 2 flag and enable word
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      t2_flags <= `MFT_T2_RST;
    end else begin
      t2_flags <= next_t2_flags;
    end
  end

  // sticky interrupt status
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      irq_stat <= 4'h0;
    end else begin
      irq_stat <= next_irq_stat;
    end
  end

  // interrupt mask
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      irq_mask <= `MFT_MASK_RST;
    end else if (wr_en && i_paddr == `MFT_OFS_IRQ_MASK) begin
      irq_mask <= i_pwdata[3:0];
    end
  end

  // read decode
  always @* begin
    rd_word = 32'h0000_0000;
    rd_hit = 1'b1;
    if (i_paddr == `MFT_OFS_T1_CTRL) begin
      rd_word = {24'h00_0000, t1_ctrl};
    end else if (i_paddr == `MFT_OFS_T2_FLAGS) begin
      rd_word = {24'h00_0000, t2_flags};
    end else if (i_paddr == `MFT_OFS_IRQ_STAT) begin
      rd_word = {28'h000_0000, irq_stat};
    end else if (i_paddr == `MFT_OFS_IRQ_MASK) begin
      rd_word = {28'h000_0000, irq_mask};
    end else if (i_paddr == `MFT_OFS_T1_COUNT) begin
      rd_word = {16'h0000, o_tmr1_count};
    end else begin
      rd_hit = 1'b0;
    end
  end

  // apb ready, one wait cycle
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_pready <= 1'b0;
    end else begin
      o_pready <= i_psel & i_penable & ~o_pready;
    end
  end

  // apb read data, zero outside the answer
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_prdata <= 32'h0000_0000;
    end else begin
      if (i_psel && i_penable && !o_pready) begin
        o_prdata <= i_pwrite ? 32'h0000_0000 : rd_word;
      end else begin
        o_prdata <= 32'h0000_0000;
      end
    end
  end

  // apb error for unmapped addresses
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_pslverr <= 1'b0;
    end else begin
      if (i_psel && i_penable && !o_pready) begin
        o_pslverr <= ~rd_hit;
      end else begin
        o_pslverr <= 1'b0;
      end
    end
  end

  // level interrupt
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(irq_stat & irq_mask);
    end
  end

endmodule
`default_nettype wire

// *** testbench/mft_ctrl_chk_asserts.sv ***
// apb and event assertions of the timer control
`timescale 1ns/10ps
`default_nettype none
module mft_ctrl_chk (
  // clock, reset and bus
  input wire i_clk,
  input wire i_rst_b,
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [7:0] i_paddr,
  input wire [31:0] o_prdata,
  input wire o_pready,
  input wire o_pslverr,
  // events
  input wire o_tmr1_capture1_evt,
  input wire o_tmr1_capture2_evt,
  input wire o_irq
);
  wire acc = i_psel && i_penable && !o_pready;
  wire hit = i_paddr inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10};
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  pready_wait_a: assert property (acc |=> o_pready)
    else $error("access not answered");
  pready_pulse_a: assert property (o_pready |=> !o_pready)
    else $error("ready longer than one cycle");
  err_ready_a: assert property (o_pslverr |-> o_pready)
    else $error("error without ready");
  rdata_idle_a: assert property (!o_pready |-> o_prdata == 32'h0)
    else $error("read data outside answer");
  addr_err_a: assert property (acc |=> o_pslverr == !$past(hit))
    else $error("error flag wrong for address");
  cap1_pulse_a: assert property (o_tmr1_capture1_evt |=> !o_tmr1_capture1_evt)
    else $error("capture one strobe too long");
  cap2_pulse_a: assert property (o_tmr1_capture2_evt |=> !o_tmr1_capture2_evt)
    else $error("capture two strobe too long");
  irq_fall_a: assert property ($fell(o_irq) |-> $past(o_pready && i_pwrite, 2))
    else $error("interrupt dropped without write");
endmodule
bind mft_timer_ctrl mft_ctrl_chk i_chk (.i_clk, .i_rst_b, .i_psel,
  .i_penable, .i_pwrite, .i_paddr, .o_prdata, .o_pready, .o_pslverr,
  .o_tmr1_capture1_evt, .o_tmr1_capture2_evt, .o_irq);
`default_nettype wire

// *** testbench/tb.sv ***
// self-checking bench of the timer control
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic i_clk = 0, i_rst_b = 0, psel = 0, pen = 0, pw = 0, rto = 0;
  logic [7:0] pa = 0;
  logic [31:0] pd = 0, r;
  logic [1:0] m2 = 0;
  logic [2:0] pin = 0;
  logic [4:0] ev = 0;
  wire [31:0] rd;
  wire [15:0] cnt;
  wire [1:0] mf;
  wire rdy, err, tk, k1, k2, irq;
  int fail_count = 0, checks = 0, cyc = 0, nt = 0, nc = 0, a, b;
  integer seed = 32'h06a8a9e7;
  logic [32:0] q[$];
  always #2 i_clk = ~i_clk;
  mft_timer_ctrl i_dut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_psel(psel),
    .i_penable(pen), .i_pwrite(pw), .i_paddr(pa), .i_pwdata(pd),
    .o_prdata(rd), .o_pready(rdy), .o_pslverr(err),
    .i_tmr1_capture1_pin(pin[0]), .i_tmr1_capture2_pin(pin[1]),
    .i_tmr1_event_pin(pin[2]), .i_rt_counter_overflow(rto),
    .i_tmr2_mode(m2), .i_tmr2_capture1_evt(ev[0]),
    .i_tmr2_capture2_evt(ev[1]), .i_tmr2_match1_evt(ev[2]),
    .i_tmr2_match2_evt(ev[3]), .i_tmr2_overflow_evt(ev[4]),
    .o_tmr1_mode_field(mf), .o_tmr1_tick(tk), .o_tmr1_capture1_evt(k1),
    .o_tmr1_capture2_evt(k2), .o_tmr1_count(cnt), .o_irq(irq));
  task automatic chk(string n, logic [32:0] s, logic [32:0] e);
    checks++;
    if (s !== e) begin
      fail_count++;
      $display("BAD %s exp %h seen %h", n, e, s);
    end
  endtask
  task final_report;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic apb(logic w, logic [7:0] ad, logic [31:0] d, logic [32:0] e);
    @(posedge i_clk);
    psel <= 1; pw <= w; pa <= ad; pd <= d; q.push_back(e);
    @(posedge i_clk);
    pen <= 1;
    @(posedge i_clk);
    while (rdy !== 1) @(posedge i_clk);
    psel <= 0; pen <= 0;
  endtask
  task automatic wr(logic [7:0] ad, logic [31:0] d);
    apb(1, ad, d, 0);
  endtask
  task automatic rx(logic [7:0] ad, logic [31:0] e);
    apb(0, ad, 0, {1'b0, e});
  endtask
  task automatic ic(logic [7:0] ad, logic [31:0] d, logic e);
    wr(ad, d);
    repeat (2) @(posedge i_clk);
    chk("irq", irq, e);
  endtask
  always @(posedge i_clk) if (rdy === 1) chk("apb", pw ? {err, 32'h0} : {err, rd}, q.pop_front());
  always @(negedge i_clk) begin
    nt += (tk === 1);
    nc += (k1 === 1) + (k2 === 1);
    if (++cyc > 20000) begin
      fail_count++;
      final_report;
    end
  end
  initial begin
    repeat (2) @(posedge i_clk);
    i_rst_b <= 1;
    rx(8'h00, 0); rx(8'h04, 0); rx(8'h08, 0); rx(8'h0c, 0);
    apb(0, 8'h14, 0, {1'b1, 32'h0});
    r = $random(seed);
    wr(0, r); rx(0, r & 8'h7f);
    @(posedge i_clk) rto <= 1;
    @(posedge i_clk) rto <= 0;
    rx(0, 8'h80 | r & 8'h7f); rx(8'h08, 1);
    wr(0, 8'h80); rx(0, 0);
    wr(4, 8'h25); m2 <= 2'h2;
    @(posedge i_clk) ev <= 5'h1f;
    @(posedge i_clk) ev <= 0;
    rx(4, 8'hff); rx(8'h08, 8'h0f);
    ic(8'h0c, 8'hf, 1); ic(8'h0c, 0, 0); ic(8'h0c, 8'hf, 1); ic(8'h08, 8'hf, 0);
    wr(4, 8'hda); rx(4, 0); m2 <= 0;
    @(posedge i_clk) ev <= 5'h15;
    @(posedge i_clk) ev <= 0;
    rx(4, 8'h0a); rx(8'h08, 0);
    for (int p = 0; p < 8; p++) begin
      wr(0, p * 4 + p % 3);
      @(posedge i_clk) a = nt;
      repeat (128) @(posedge i_clk);
      chk("tick", nt - a, 128 >> p);
      chk("mode", mf, p % 3);
    end
    for (int i = 0; i < 4; i++) begin
      wr(0, i[0] * 8'h60 + 2 + i[1]);
      @(posedge i_clk) pin <= 3'h7;
      a = nc; b = nt;
      repeat (8) @(posedge i_clk);
      chk("cap", nc - a, i[1] ? 0 : 2 * i[0]);
      chk("evt", i[1] ? nt - b : 0, i[1] ? i[0] : 0);
      pin <= 0;
      repeat (8) @(posedge i_clk);
      chk("cap", nc - a, i[1] ? 0 : 2);
      chk("evt", i[1] ? nt - b : 1, 1);
    end
    @(posedge i_clk);
    chk("count", cnt, nt & 16'hffff);
    rx(8'h10, nt & 16'hffff);
    final_report;
  end
endmodule
`default_nettype wire
